/* File: design/tcs_pkg.sv */
// constants, field layout and helpers for the timer prescale and transfer stretch block
package tcs_pkg;

  // register location and layout
  localparam logic [7:0] TCS_CTRL_ADDR = 8'h8e;
  localparam logic [5:0] TCS_CTRL_RESET = 6'h01;
  localparam int TCS_T2_SEL_BIT = 5;
  localparam int TCS_T1_SEL_BIT = 4;
  localparam int TCS_T0_SEL_BIT = 3;
  localparam int TCS_STRETCH_MSB = 2;
  localparam int TCS_STRETCH_LSB = 0;
  localparam logic [1:0] TCS_RSVD_READ = 2'h0;

  // prescale divider
  localparam logic [3:0] TCS_DIV_LAST = 4'hb;
  localparam logic [1:0] TCS_FAST_PHASE = 2'h3;

  // transfer timing in system clocks
  localparam logic [5:0] TCS_CLKS_PER_ICYCLE = 6'h04;
  localparam logic [5:0] TCS_MIN_ICYCLES = 6'h02;
  localparam logic [5:0] TCS_STROBE_LEAD = 6'h04;
  localparam logic [5:0] TCS_STROBE_MIN = 6'h02;
  localparam logic [5:0] TCS_ONCHIP_CLKS = 6'h08;

  // sequencer states
  typedef enum logic [1:0] {
    TCS_IDLE = 2'b01,
    TCS_BUSY = 2'b10
  } tcs_state_t;

  // whole transfer length in clocks for stretch n
  function automatic logic [5:0] tcs_xfer_clks(input logic [2:0] n);
    tcs_xfer_clks = 6'(TCS_CLKS_PER_ICYCLE * ({3'h0, n} + TCS_MIN_ICYCLES));
  endfunction : tcs_xfer_clks

  // strobe width in clocks for stretch n
  function automatic logic [5:0] tcs_strobe_clks(input logic [2:0] n);
    if (n == 3'h0)
      tcs_strobe_clks = TCS_STROBE_MIN;
    else
      tcs_strobe_clks = 6'(TCS_CLKS_PER_ICYCLE * {3'h0, n});
  endfunction : tcs_strobe_clks

endpackage : tcs_pkg

/* File: design/tcs_top.sv */
// timer rate prescaler, control register and external transfer stretch sequencer
`timescale 1ns/10ps
module tcs_top
  import tcs_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // special function register access
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // timer mode inputs from the timer blocks
  input wire logic TMR0_CNT_MODE,
  input wire logic TMR1_CNT_MODE,
  input wire logic TMR2_CNT_MODE,
  input wire logic TMR2_BAUD_OR_CLKOUT,
  // external count pins
  input wire logic TMR0_PIN,
  input wire logic TMR1_PIN,
  input wire logic TMR2_PIN,
  // increment pulses to the timers
  output logic TMR0_INC,
  output logic TMR1_INC,
  output logic TMR2_INC,
  // external data transfer request from the core
  input wire logic XFER_START,
  input wire logic XFER_WRITE,
  input wire logic XFER_ONCHIP,
  // external data transfer strobes and status
  output logic EXT_RD_N,
  output logic EXT_WR_N,
  output logic XFER_BUSY,
  output logic XFER_DONE
);

  // register state
  logic [5:0] ctrl_reg, ctrl_next;
  logic [7:0] rdata_reg, rdata_next;
  // prescaler state
  logic [3:0] div_reg, div_next;
  logic tick4_reg, tick4_next;
  logic tick12_reg, tick12_next;
  logic [2:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [2:0] inc_reg, inc_next;
  logic [2:0] pin_fall;
  // transfer sequencer state
  tcs_state_t state_reg, state_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [5:0] len_reg, len_next;
  logic [5:0] slen_reg, slen_next;
  logic onchip_reg, onchip_next;
  logic write_reg, write_next;
  logic rd_n_reg, rd_n_next;
  logic wr_n_reg, wr_n_next;
  logic done_reg, done_next;
  logic strobe_on;

  // control register write and read
  always_comb
  begin
    ctrl_next = ctrl_reg;
    // stretch and rate bits are writable
    if (SFR_WR && (SFR_ADDR == TCS_CTRL_ADDR))
      ctrl_next = SFR_WDATA[TCS_T2_SEL_BIT:TCS_STRETCH_LSB];
    // top two bits read back as zero
    rdata_next = (SFR_ADDR == TCS_CTRL_ADDR) ? {TCS_RSVD_READ, ctrl_reg} : 8'h00;
  end

  // free-running divider, never touched by instruction flow
  always_comb
  begin
    div_next = (div_reg == TCS_DIV_LAST) ? 4'h0 : div_reg + 4'h1;
    tick4_next = (div_next[1:0] == TCS_FAST_PHASE);
    tick12_next = (div_next == TCS_DIV_LAST);
  end

  // edge of a synchronised pin; only the second and third stages are read
  assign pin_fall = pin_s3_reg & ~pin_s2_reg;

  // per timer increment selection
  always_comb
  begin
    // counter mode follows the pin, timer mode the prescaler
    inc_next[0] = TMR0_CNT_MODE ? pin_fall[0]
                : (ctrl_reg[TCS_T0_SEL_BIT] ? tick4_reg : tick12_reg);
    inc_next[1] = TMR1_CNT_MODE ? pin_fall[1]
                : (ctrl_reg[TCS_T1_SEL_BIT] ? tick4_reg : tick12_reg);
    inc_next[2] = TMR2_CNT_MODE ? pin_fall[2]
                : (ctrl_reg[TCS_T2_SEL_BIT] ? tick4_reg : tick12_reg);
    // baud or clock-out mode ignores the select bit
    if (TMR2_BAUD_OR_CLKOUT && !TMR2_CNT_MODE)
      inc_next[2] = tick12_reg;
  end

  // transfer sequencer; stretch is latched at start so a write mid-transfer is safe
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    len_next = len_reg;
    slen_next = slen_reg;
    onchip_next = onchip_reg;
    write_next = write_reg;
    done_next = 1'b0;
    unique case (state_reg)
      TCS_IDLE:
      begin
        if (XFER_START)
        begin
          state_next = TCS_BUSY;
          cnt_next = 6'h00;
          onchip_next = XFER_ONCHIP;
          write_next = XFER_WRITE;
          // on-chip transfers ignore the stretch field
          // length and strobe width from stretch value
          len_next = XFER_ONCHIP ? TCS_ONCHIP_CLKS
                   : tcs_xfer_clks(ctrl_reg[TCS_STRETCH_MSB:TCS_STRETCH_LSB]);
          slen_next = tcs_strobe_clks(ctrl_reg[TCS_STRETCH_MSB:TCS_STRETCH_LSB]);
        end
      end
      TCS_BUSY:
      begin
        if (cnt_reg == len_reg - 6'h01)
        begin
          state_next = TCS_IDLE;
          done_next = 1'b1;
        end
        else
          cnt_next = cnt_reg + 6'h01;
      end
    endcase
    // strobe low for the stretched window after a four-clock lead
    strobe_on = (state_next == TCS_BUSY) && !onchip_next
              && (cnt_next >= TCS_STROBE_LEAD) && (cnt_next < TCS_STROBE_LEAD + slen_next);
    rd_n_next = !(strobe_on && !write_next);
    wr_n_next = !(strobe_on && write_next);
  end

  // register everything on one clock
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      ctrl_reg <= TCS_CTRL_RESET;
      rdata_reg <= 8'h00;
      div_reg <= 4'h0;
      tick4_reg <= 1'b0;
      tick12_reg <= 1'b0;
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
      pin_s3_reg <= 3'h0;
      inc_reg <= 3'h0;
      state_reg <= TCS_IDLE;
      cnt_reg <= 6'h00;
      len_reg <= TCS_ONCHIP_CLKS;
      slen_reg <= TCS_STROBE_MIN;
      onchip_reg <= 1'b0;
      write_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      done_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      div_reg <= div_next;
      tick4_reg <= tick4_next;
      tick12_reg <= tick12_next;
      pin_s1_reg <= {TMR2_PIN, TMR1_PIN, TMR0_PIN};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      inc_reg <= inc_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      slen_reg <= slen_next;
      onchip_reg <= onchip_next;
      write_reg <= write_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      done_reg <= done_next;
    end
  end

  // outputs straight from flops, except XFER_BUSY decoded from state_reg
  assign SFR_RDATA = rdata_reg;
  // single-count pulses only, timers add one each
  assign TMR0_INC = inc_reg[0];
  assign TMR1_INC = inc_reg[1];
  assign TMR2_INC = inc_reg[2];
  // instruction timing never reads the rate bits
  assign EXT_RD_N = rd_n_reg;
  assign EXT_WR_N = wr_n_reg;
  assign XFER_BUSY = (state_reg == TCS_BUSY);
  assign XFER_DONE = done_reg;

  // helper: counts strobe-low cycles for the width check
  logic [5:0] low_cnt_reg;
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      low_cnt_reg <= 6'h00;
    else if (!(rd_n_reg && wr_n_reg))
      low_cnt_reg <= low_cnt_reg + 6'h01;
    else
      low_cnt_reg <= 6'h00;
  end

  property p_rsvd_zero;
    @(posedge CLK_SYS) disable iff (SRST)
    SFR_RDATA[7:6] == 2'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");

  property p_reset_value;
    @(posedge CLK_SYS) disable iff (SRST)
    $past(SRST) |-> (ctrl_reg == TCS_CTRL_RESET);
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("control register not at reset value");

  property p_fast_period;
    @(posedge CLK_SYS) disable iff (SRST)
    tick4_reg |-> ##1 !tick4_reg [*3] ##1 tick4_reg;
  endproperty
  a_fast_period: assert property (p_fast_period)
    else $error("fast tick period is not four clocks");

  property p_slow_period;
    @(posedge CLK_SYS) disable iff (SRST)
    // eleven quiet cycles, then the next slow tick exactly twelve clocks on
    tick12_reg |-> ##1 !tick12_reg [*8] ##1 !tick12_reg [*3] ##1 tick12_reg;
  endproperty
  a_slow_period: assert property (p_slow_period)
    else $error("slow tick period is not twelve clocks");

  property p_t2_fast;
    @(posedge CLK_SYS) disable iff (SRST)
    (tick4_reg && ctrl_reg[TCS_T2_SEL_BIT] && !TMR2_CNT_MODE && !TMR2_BAUD_OR_CLKOUT)
      |-> ##1 TMR2_INC;
  endproperty
  a_t2_fast: assert property (p_t2_fast)
    else $error("timer 2 fast increment missing");

  property p_t2_baud;
    @(posedge CLK_SYS) disable iff (SRST)
    (TMR2_BAUD_OR_CLKOUT && !TMR2_CNT_MODE) |-> ##1 (TMR2_INC == $past(tick12_reg));
  endproperty
  a_t2_baud: assert property (p_t2_baud)
    else $error("timer 2 select acted in baud mode");

  property p_t1_slow;
    @(posedge CLK_SYS) disable iff (SRST)
    (!TMR1_CNT_MODE && !ctrl_reg[TCS_T1_SEL_BIT]) |-> ##1 (TMR1_INC == $past(tick12_reg));
  endproperty
  a_t1_slow: assert property (p_t1_slow)
    else $error("timer 1 slow increment wrong");

  property p_t0_fast;
    @(posedge CLK_SYS) disable iff (SRST)
    (!TMR0_CNT_MODE && ctrl_reg[TCS_T0_SEL_BIT]) |-> ##1 (TMR0_INC == $past(tick4_reg));
  endproperty
  a_t0_fast: assert property (p_t0_fast)
    else $error("timer 0 fast increment wrong");

  property p_onchip_len;
    @(posedge CLK_SYS) disable iff (SRST)
    (XFER_START && !XFER_BUSY && XFER_ONCHIP)
      |-> ##1 (EXT_RD_N && EXT_WR_N && !XFER_DONE) [*8] ##1 XFER_DONE;
  endproperty
  a_onchip_len: assert property (p_onchip_len)
    else $error("on-chip transfer not two instruction cycles");

  property p_strobe_width;
    @(posedge CLK_SYS) disable iff (SRST)
    ($rose(EXT_RD_N) || $rose(EXT_WR_N)) |-> (low_cnt_reg == slen_reg);
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe width differs from stretch setting");

  property p_strobe_in_xfer;
    @(posedge CLK_SYS) disable iff (SRST)
    !(EXT_RD_N && EXT_WR_N) |-> (XFER_BUSY && !onchip_reg && !(EXT_RD_N == EXT_WR_N));
  endproperty
  a_strobe_in_xfer: assert property (p_strobe_in_xfer)
    else $error("strobe outside an external transfer");

endmodule : tcs_top

/* File: bench/tcs_ext_mem.sv */
// slow external memory model sitting on the stretched strobes
`timescale 1ns/10ps
module tcs_ext_mem
(
  // clock, reset and strobes
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_n,
  input wire logic wr_n,
  // what the last access looked like
  output logic [5:0] width,
  output logic last_wr,
  output logic [7:0] n_acc
);
  logic [5:0] run;
  logic wr_seen;
  // finish at strobe release
  // access completes at strobe release, so a short strobe shows as a short width
  // one process owns every variable here, so reset rather than initial values
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run <= 6'h00;
      wr_seen <= 1'b0;
      width <= 6'h00;
      last_wr <= 1'b0;
      n_acc <= 8'h00;
    end
    else if (!rd_n || !wr_n)
    begin
      run <= run + 6'h01;
      wr_seen <= !wr_n;
    end
    else if (run != 6'h00)
    begin
      width <= run;
      last_wr <= wr_seen;
      n_acc <= n_acc + 8'h01;
      run <= 6'h00;
    end
  end
endmodule : tcs_ext_mem

/* File: bench/tcs_top_tb.sv */
// self-checking bench for the timer prescale and transfer stretch block
`timescale 1ns/10ps
module tcs_top_tb
  import tcs_pkg::*;
;
  logic clk, srst, wr, start, xwr, onchip, baud;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] cnt, pin;
  // each bit driven by its own output port, so a net
  wire [2:0] inc;
  logic rd_n, wr_n, busy, done, last_wr;
  logic [5:0] width;
  logic [7:0] n_acc;
  int fail_count, n_compared;

  // design and the external part on its strobes
  tcs_top DUT (.CLK_SYS(clk), .SRST(srst), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_WDATA(wdata),
    .SFR_RDATA(rdata), .TMR0_CNT_MODE(cnt[0]), .TMR1_CNT_MODE(cnt[1]),
    .TMR2_CNT_MODE(cnt[2]), .TMR2_BAUD_OR_CLKOUT(baud), .TMR0_PIN(pin[0]),
    .TMR1_PIN(pin[1]), .TMR2_PIN(pin[2]), .TMR0_INC(inc[0]), .TMR1_INC(inc[1]),
    .TMR2_INC(inc[2]), .XFER_START(start), .XFER_WRITE(xwr), .XFER_ONCHIP(onchip),
    .EXT_RD_N(rd_n), .EXT_WR_N(wr_n), .XFER_BUSY(busy), .XFER_DONE(done));
  tcs_ext_mem u_mem (.clk(clk), .rst(srst), .rd_n(rd_n), .wr_n(wr_n), .width(width),
    .last_wr(last_wr), .n_acc(n_acc));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // inputs always move 1 ns after the rising edge
  task tick;
    @(posedge clk);
    #1;
  endtask : tick

  task limit(input int k, input int lim);
    if (k >= lim)
    begin
      fail_count++;
      report_and_stop;
    end
  endtask : limit

  task sfr_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick;
    wr = 1'b0;
  endtask : sfr_wr

  task sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    tick;
    chk(rdata, exp);
  endtask : sfr_rd

  task t_reg;
    sfr_rd(TCS_CTRL_ADDR, 8'h01);
    sfr_rd(8'h8d, 8'h00);
    sfr_wr(TCS_CTRL_ADDR, 8'hff);
    sfr_rd(TCS_CTRL_ADDR, 8'h3f);
    sfr_wr(8'h8d, 8'h00);
    sfr_rd(TCS_CTRL_ADDR, 8'h3f);
    srst = 1'b1;
    tick;
    srst = 1'b0;
    sfr_rd(TCS_CTRL_ADDR, 8'h01);
  endtask : t_reg

  // second pass measures a whole pulse-to-pulse interval
  task period(input int i, input logic [7:0] exp);
    int k;
    repeat (2)
    begin
      k = 0;
      do
      begin
        tick;
        k++;
      end while (inc[i] !== 1'b1 && k < 30);
      limit(k, 30);
    end
    chk(8'(k), exp);
  endtask : period

  task t_rates;
    int i, j;
    for (j = 0; j < 3; j++)
      period(j, 8'd12);
    for (i = 0; i < 3; i++)
    begin
      sfr_wr(TCS_CTRL_ADDR, 8'h01 | (8'h08 << i));
      for (j = 0; j < 3; j++)
        period(j, (i == j) ? 8'd4 : 8'd12);
    end
    baud = 1'b1;
    period(2, 8'd12);
    baud = 1'b0;
  endtask : t_rates

  task t_count;
    int i, j, c;
    cnt = 3'h7;
    for (i = 0; i < 3; i++)
    begin
      repeat (4) tick;
      pin[i] = 1'b0;
      c = 0;
      for (j = 0; j < 12; j++)
      begin
        tick;
        c += (inc[i] === 1'b1);
      end
      chk(8'(c), 8'h01);
      pin[i] = 1'b1;
    end
    cnt = 3'h0;
  endtask : t_count

  // poke retries a start while busy; it must be dropped
  task xfer(input logic [2:0] n, input logic w, input logic oc, input logic poke);
    int k;
    logic [7:0] acc;
    sfr_wr(TCS_CTRL_ADDR, {5'h00, n});
    acc = n_acc;
    start = 1'b1;
    xwr = w;
    onchip = oc;
    for (k = 0; k < 60 && done !== 1'b1; k++)
    begin
      tick;
      start = poke && k == 1;
    end
    limit(k, 60);
    chk(8'(k), oc ? 8'd9 : 8'(4 * n + 9));
    chk(n_acc - acc, oc ? 8'h00 : 8'h01);
    if (!oc)
    begin
      chk({2'h0, width}, (n == 3'h0) ? 8'd2 : 8'(4 * n));
      chk({7'h00, last_wr}, {7'h00, w});
    end
    if (poke)
    begin
      tick;
      chk({7'h00, busy}, 8'h00);
    end
  endtask : xfer

  task t_xfer;
    int n;
    for (n = 0; n < 8; n++)
      xfer(3'(n), n[0], 1'b0, 1'b0);
    xfer(3'h7, 1'b0, 1'b1, 1'b0);
    xfer(3'h2, 1'b1, 1'b0, 1'b1);
  endtask : t_xfer

  // reset for two cycles, then each scenario in turn
  initial
  begin
    srst = 1'b1;
    {wr, start, xwr, onchip, baud} = 5'h00;
    addr = 8'h00;
    wdata = 8'h00;
    cnt = 3'h0;
    pin = 3'h7;
    fail_count = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reg;
    t_rates;
    t_count;
    t_xfer;
    report_and_stop;
  end
endmodule : tcs_top_tb
